//--- rtl/pss_pkg.sv
package pss_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_POL    = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_DUTY   = 12'h00C;
  localparam logic [11:0] OFF_SCRIPT = 12'h200;
  localparam logic [11:0] OFF_SCREND = 12'h380;
  localparam int          CTRL_START_LSB = 0;
  localparam int          CTRL_STOP_LSB  = 4;
  localparam int          STAT_RUN_LSB   = 0;
  localparam int          STAT_DONE_LSB  = 4;
  localparam int          STAT_TRIG_LSB  = 8;
  localparam int          DUTY_W         = 8;
  localparam int          CH_SEL_LSB     = 7;
  localparam int          IDX_LSB        = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [8:0]  DIV_FAST  = 9'h00F;
  localparam logic [8:0]  DIV_SLOW  = 9'h1FF;
  localparam logic [4:0]  TRIG_LAST = 5'h0F;

  // ---------------------------------------------------------------
  // Instruction fields
  // ---------------------------------------------------------------
  localparam logic [15:0] INS_JUMP_FIRST = 16'h0000;
  localparam logic [7:0]  INS_SET_HI     = 8'h40;
  localparam int          RAMP_PRE_BIT   = 14;
  localparam int          RAMP_DIR_BIT   = 7;
  localparam int          BR_ADDR_BIT    = 6;
  localparam int          END_INT_BIT    = 11;
  localparam logic [7:0]  DUTY_FULL      = 8'hFF;
  localparam logic [7:0]  DUTY_ZERO      = 8'h00;

  typedef enum logic [2:0] {
    OP_RAMP  = 3'b000,
    OP_SET   = 3'b001,
    OP_FIRST = 3'b010,
    OP_BR    = 3'b011,
    OP_END   = 3'b100,
    OP_TRIG  = 3'b101,
    OP_NOP   = 3'b110
  } pss_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RAMP = 2'b10,
    ST_TRIG = 2'b11
  } pss_st_t;
endpackage

//--- rtl/pss_sequencer.sv
`timescale 1ns/10ps
// What this block does
// - Prescale bit picks divide 16 or 512
// - Step duration counts prescaled cycles per step
// - Direction bit: 0 increments, 1 decrements duty
// - Step count sets steps; zero is one delay
// - Jump-to-first returns counter to word zero
// - Branch target absolute or backward by mode
// - Branch repeats count times; zero loops forever
// - Trigger send sixteen slow cycles, wait more
// - Wait stalls until all masked triggers present
// - Triggers latched until receiver waits on them
// - Trigger masks select channels zero to two
// - End stops script, notify bit raises done
// - End drives output to idle polarity level
// - End returns counter to buffer start
// - Notify bit sets channel done raw flag
// - Halt during trigger wait: no done flag
// - Each channel holds thirty-two word script
// - Timers run from slow clock ticks
module pss_sequencer #(
  parameter int NCH   = 3,
  parameter int DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        slow_clk,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic [NCH-1:0]   pwm_out
);
  localparam int PW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                                ack;
    logic [31:0]                         rdat;
    logic                                slow_prev;
    logic [7:0]                          pwm_cnt;
    logic [NCH-1:0]                      output_idle_polarity;
    logic [NCH-1:0]                      script_done_raw_flag;
    logic [NCH-1:0]                      run;
    logic [NCH-1:0]                      out;
    logic [NCH-1:0][NCH-1:0]             trig;
    logic [NCH-1:0]                      loop_act;
    logic [NCH-1:0][5:0]                 loop_cnt;
    pss_pkg::pss_st_t [NCH-1:0]          st;
    logic [NCH-1:0][PW-1:0]              pc;
    logic [NCH-1:0][7:0]                 duty_value;
    logic [NCH-1:0][8:0]                 pre;
    logic [NCH-1:0][5:0]                 stc;
    logic [NCH-1:0][6:0]                 rem;
    logic [NCH-1:0][4:0]                 tcnt;
    logic [NCH-1:0][DEPTH-1:0][15:0]     mem;
  } pss_state_t;

  pss_state_t q;
  pss_state_t n;
  logic        req;
  logic        tick;
  logic        in_script;
  logic [1:0]  w_ch;
  logic [PW-1:0] w_idx;
  logic [NCH-1:0] set_trig;
  logic [NCH-1:0] clr_trig;
  logic [15:0] ins;
  logic [5:0]  sdur;
  logic [5:0]  wmask;

  function automatic pss_pkg::pss_op_t pss_decode(input logic [15:0] w);
    pss_decode = pss_pkg::OP_NOP;
    if (w == pss_pkg::INS_JUMP_FIRST)
      pss_decode = pss_pkg::OP_FIRST;
    else if (w[15:8] == pss_pkg::INS_SET_HI)
      pss_decode = pss_pkg::OP_SET;
    else if (!w[15])
      pss_decode = pss_pkg::OP_RAMP;
    else if (w[15:13] == 3'b101)
      pss_decode = pss_pkg::OP_BR;
    else if (w[15:12] == 4'b1101)
      pss_decode = pss_pkg::OP_END;
    else if (w[15:13] == 3'b111)
      pss_decode = pss_pkg::OP_TRIG;
  endfunction

  assign req       = wb_cyc_i & wb_stb_i & ~q.ack;
  assign tick      = slow_clk & ~q.slow_prev;
  assign in_script = (wb_adr_i >= pss_pkg::OFF_SCRIPT) && (wb_adr_i < pss_pkg::OFF_SCREND);
  assign w_ch      = wb_adr_i[pss_pkg::CH_SEL_LSB +: 2] - 2'h0;
  assign w_idx     = wb_adr_i[pss_pkg::IDX_LSB +: PW];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n         = q;
    set_trig  = '0;
    clr_trig  = '0;
    ins       = '0;
    sdur      = '0;
    wmask     = '0;
    n.slow_prev = slow_clk;
    n.ack     = req;
    if (tick)
      n.pwm_cnt = q.pwm_cnt + 8'h01;

    for (int c = 0; c < NCH; c++)
    begin
      ins  = q.mem[c][q.pc[c]];
      sdur = (ins[13:8] == 6'h00) ? 6'h01 : ins[13:8];
      case (q.st[c])
        pss_pkg::ST_EXEC:
        begin
          n.pc[c] = q.pc[c] + PW'(1);
          n.pre[c] = '0;
          n.stc[c] = '0;
          n.tcnt[c] = '0;
          case (pss_decode(ins))
            pss_pkg::OP_RAMP:
            begin
              // zero count is one delay step
              n.rem[c] = (ins[6:0] == 7'h00) ? 7'h01 : ins[6:0];
              n.pc[c] = q.pc[c];
              n.st[c] = pss_pkg::ST_RAMP;
            end
            pss_pkg::OP_SET: n.duty_value[c] = ins[7:0];
            pss_pkg::OP_FIRST: n.pc[c] = '0;
            pss_pkg::OP_BR:
            begin
              if (!q.loop_act[c] || ins[12:7] == 6'h00 || q.loop_cnt[c] > 6'h01)
              begin
                n.pc[c] = ins[pss_pkg::BR_ADDR_BIT] ? PW'(q.pc[c] - ins[PW-1:0]) : ins[PW-1:0];
                n.loop_act[c] = 1'b1;
                n.loop_cnt[c] = q.loop_act[c] ? q.loop_cnt[c] - 6'h01 : ins[12:7];
              end
              else
                n.loop_act[c] = 1'b0;
            end
            pss_pkg::OP_END:
            begin
              n.run[c] = 1'b0;
              n.st[c] = pss_pkg::ST_IDLE;
              n.pc[c] = '0;
              n.loop_act[c] = 1'b0;
              if (ins[pss_pkg::END_INT_BIT])
                n.script_done_raw_flag[c] = 1'b1;
            end
            pss_pkg::OP_TRIG:
            begin
              set_trig = set_trig | ins[1 +: NCH];
              n.pc[c] = q.pc[c];
              n.st[c] = pss_pkg::ST_TRIG;
            end
            default: ;
          endcase
        end
        pss_pkg::ST_RAMP:
        begin
          if (tick)
          begin
            n.pre[c] = q.pre[c] + 9'h001;
            if (q.pre[c] == (ins[pss_pkg::RAMP_PRE_BIT] ? pss_pkg::DIV_SLOW : pss_pkg::DIV_FAST))
            begin
              n.pre[c] = '0;
              n.stc[c] = q.stc[c] + 6'h01;
              if (q.stc[c] >= sdur - 6'h01)
              begin
                n.stc[c] = '0;
                n.rem[c] = q.rem[c] - 7'h01;
                if (ins[6:0] != 7'h00)
                begin
                  if (!ins[pss_pkg::RAMP_DIR_BIT] && q.duty_value[c] != pss_pkg::DUTY_FULL)
                    n.duty_value[c] = q.duty_value[c] + 8'h01;
                  else if (ins[pss_pkg::RAMP_DIR_BIT] && q.duty_value[c] != pss_pkg::DUTY_ZERO)
                    n.duty_value[c] = q.duty_value[c] - 8'h01;
                end
                if (q.rem[c] == 7'h01)
                begin
                  n.pc[c] = q.pc[c] + PW'(1);
                  n.st[c] = pss_pkg::ST_EXEC;
                end
              end
            end
          end
        end
        pss_pkg::ST_TRIG:
        begin
          wmask = ins[12:7];
          if (tick && q.tcnt[c] != pss_pkg::TRIG_LAST)
            n.tcnt[c] = q.tcnt[c] + 5'h01;
          if (tick && q.tcnt[c] == pss_pkg::TRIG_LAST
              && (q.trig[c] & wmask[NCH-1:0]) == wmask[NCH-1:0])
          begin
            clr_trig[c] = 1'b1;
            n.pc[c] = q.pc[c] + PW'(1);
            n.st[c] = pss_pkg::ST_EXEC;
          end
        end
        default: ;
      endcase
    end

    // latch until waiter clears; set wins
    for (int c = 0; c < NCH; c++)
    begin
      wmask = q.mem[c][q.pc[c]][12:7];
      if (clr_trig[c])
        n.trig[c] = q.trig[c] & ~wmask[NCH-1:0];
      for (int s = 0; s < NCH; s++)
        if (set_trig[c] && q.st[s] == pss_pkg::ST_EXEC)
          n.trig[c][s] = n.trig[c][s] | (pss_decode(q.mem[s][q.pc[s]]) == pss_pkg::OP_TRIG
                                         && q.mem[s][q.pc[s]][1 + c]);
    end

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    n.rdat = '0;
    if (req && !wb_we_i)
    begin
      if (wb_adr_i == pss_pkg::OFF_POL)
        n.rdat[NCH-1:0] = q.output_idle_polarity;
      else if (wb_adr_i == pss_pkg::OFF_STATUS)
      begin
        n.rdat[pss_pkg::STAT_RUN_LSB +: NCH]  = q.run;
        n.rdat[pss_pkg::STAT_DONE_LSB +: NCH] = q.script_done_raw_flag;
        for (int c = 0; c < NCH; c++)
          n.rdat[pss_pkg::STAT_TRIG_LSB + c * 4 +: NCH] = q.trig[c];
      end
      else if (wb_adr_i == pss_pkg::OFF_DUTY)
        n.rdat[NCH * pss_pkg::DUTY_W - 1:0] = q.duty_value;
      else if (in_script)
        n.rdat[15:0] = q.mem[w_ch][w_idx];
    end
    if (req && wb_we_i)
    begin
      if (wb_adr_i == pss_pkg::OFF_CTRL && wb_sel_i[0])
        for (int c = 0; c < NCH; c++)
        begin
          if (wb_dat_i[pss_pkg::CTRL_STOP_LSB + c])
          begin
            n.run[c] = 1'b0;
            n.st[c] = pss_pkg::ST_IDLE;
            n.pc[c] = '0;
            n.loop_act[c] = 1'b0;
          end
          else if (wb_dat_i[pss_pkg::CTRL_START_LSB + c] && !q.run[c])
          begin
            n.run[c] = 1'b1;
            n.st[c] = pss_pkg::ST_EXEC;
          end
        end
      else if (wb_adr_i == pss_pkg::OFF_POL && wb_sel_i[0])
        n.output_idle_polarity = wb_dat_i[NCH-1:0];
      else if (wb_adr_i == pss_pkg::OFF_STATUS && wb_sel_i[0])
        n.script_done_raw_flag = n.script_done_raw_flag
                               & ~(wb_dat_i[pss_pkg::STAT_DONE_LSB +: NCH] & ~(n.script_done_raw_flag
                               & ~q.script_done_raw_flag));
      else if (in_script)
      begin
        if (wb_sel_i[0])
          n.mem[w_ch][w_idx][7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1])
          n.mem[w_ch][w_idx][15:8] = wb_dat_i[15:8];
      end
    end

    for (int c = 0; c < NCH; c++)
      n.out[c] = n.run[c] ? (((n.duty_value[c] == pss_pkg::DUTY_FULL) || (n.pwm_cnt < n.duty_value[c]))
                            ^ n.output_idle_polarity[c]) : n.output_idle_polarity[c];
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= n;
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign pwm_out  = q.out;
endmodule // pss_sequencer

//--- testbench/pss_sequencer_assertions.sv
`timescale 1ns/10ps
// ------------------------------
// Port checker
// ------------------------------
module pss_sequencer_assertions #(
  parameter int NCH = 3
) (
  input wire logic           clk,
  input wire logic           resetn,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic [11:0]    wb_adr_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  input wire logic [NCH-1:0] pwm_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic rd = wb_ack_o && !wb_we_i;
  wire logic scr = wb_adr_i >= pss_pkg::OFF_SCRIPT && wb_adr_i < pss_pkg::OFF_SCREND;

  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_zero: assert property (p_dat_zero)
    else $error("read data outside ack");
  property p_scr_hi; rd && scr |-> wb_dat_o[31:16] == 16'h0; endproperty
  a_scr_hi: assert property (p_scr_hi)
    else $error("script word upper half not zero");
  property p_ctrl_rd; rd && wb_adr_i == pss_pkg::OFF_CTRL |-> wb_dat_o == 32'h0; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control read not zero");
  property p_stat_rsv;
    rd && wb_adr_i == pss_pkg::OFF_STATUS |-> (wb_dat_o & 32'hFFF08888) == 32'h0;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv)
    else $error("status spare bits set");
  property p_rst_idle; $rose(resetn) |-> pwm_out == '0; endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("output not idle after reset");
  c_read: cover property (rd && scr);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_pwm: cover property ($rose(pwm_out[0]));
endmodule // pss_sequencer_assertions

//--- testbench/pss_led_load.sv
`timescale 1ns/10ps
// ------------------------------
// LED load on channel 0
// ------------------------------
module pss_led_load (
  input wire logic        clk,
  input wire logic [2:0]  drive,
  output logic     [15:0] lit_cnt
);
  initial lit_cnt = 16'h0;
  always @(posedge clk)
    lit_cnt <= lit_cnt + 16'(drive[0]);
endmodule // pss_led_load

//--- testbench/pss_sequencer_tb.sv
`timescale 1ns/10ps
module pss_sequencer_tb;
  localparam logic [11:0] ST = pss_pkg::OFF_STATUS;
  localparam logic [11:0] CT = pss_pkg::OFF_CTRL;
  localparam logic [11:0] DU = pss_pkg::OFF_DUTY;
  localparam logic [11:0] PO = pss_pkg::OFF_POL;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        slow_clk = 1'b0;
  logic [2:0]  div = 3'h0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic [2:0]  pwm;
  logic [15:0] lit;
  logic [31:0] rv;
  logic [15:0] br [2] = '{16'hA101, 16'hA141};
  int          n_mismatch = 0;
  int          comparisons = 0;

  always #20 clk = ~clk;
  // Slow tick every eight clocks
  always @(posedge clk)
  begin
    div <= div + 3'h1;
    slow_clk <= div[2];
  end

  pss_sequencer pss_sequencer_i (.clk(clk), .resetn(resetn), .slow_clk(slow_clk), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .pwm_out(pwm));
  pss_led_load pss_led_load_i (.clk(clk), .drive(pwm), .lit_cnt(lit));

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rv = dat_o;
    if (n >= 50)
      n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask

  task automatic pchk(logic [2:0] e);
    repeat (2) @(posedge clk);
    chk("pwm", {29'h0, pwm}, {29'h0, e});
  endtask

  task automatic ld(int c, logic [15:0] w0, logic [15:0] w1, logic [15:0] w2, logic [15:0] w3);
    logic [15:0] w [4];
    w = '{w0, w1, w2, w3};
    for (int i = 0; i < 4; i++)
      bus(1'b1, pss_pkg::OFF_SCRIPT + 12'(c * 128 + i * 4), {16'h0, w[i]});
  endtask

  task automatic start(logic [31:0] m);
    int n;
    n = 0;
    bus(1'b1, ST, 32'h70);
    bus(1'b1, CT, m);
    do
    begin
      bus(1'b0, ST, 32'h0);
      n++;
    end
    while (rv[2:0] !== 3'h0 && n < 2000);
    if (n >= 2000)
      n_mismatch++;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------
  // Tests
  // ------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk("pol", PO, 32'h0);
    rchk("unmapped", 12'h100, 32'h0);
    ld(0, 16'h40FF, 16'hD800, 16'h0, 16'h0);
    rchk("word", pss_pkg::OFF_SCRIPT + 12'h004, 32'hD800);
    bus(1'b1, PO, 32'h5);
    start(32'h1);
    rchk("status", ST, 32'h10);
    rchk("duty", DU, 32'hFF);
    pchk(3'h5);
    bus(1'b1, PO, 32'h0);
    ld(0, 16'h40FF, 16'h0000, 16'hD800, 16'h0);
    bus(1'b1, ST, 32'h70);
    bus(1'b1, CT, 32'h1);
    repeat (40) @(posedge clk);
    rchk("status", ST, 32'h1);
    pchk(3'h1);
    bus(1'b1, CT, 32'h10);
    rchk("status", ST, 32'h0);
    pchk(3'h0);
    chk("lit", {31'h0, lit != 16'h0}, 32'h1);
    ld(1, 16'h4010, 16'h0103, 16'h0181, 16'hD000);
    start(32'h2);
    rchk("status", ST, 32'h0);
    rchk("duty", DU, 32'h12FF);
    // branch scripts hold no nested loops
    for (int i = 0; i < 2; i++)
    begin
      ld(2, 16'h4000, 16'h0101, br[i], 16'hD800);
      start(32'h4);
      rchk("status", ST, 32'h40);
      rchk("duty", DU, 32'h0312FF);
    end
    ld(0, 16'hE00C, 16'hD800, 16'h0, 16'h0);
    ld(1, 16'hE080, 16'h4055, 16'hD800, 16'h0);
    bus(1'b1, ST, 32'h70);
    bus(1'b1, CT, 32'h2);
    repeat (200) @(posedge clk);
    rchk("status", ST, 32'h2);
    start(32'h1);
    rchk("status", ST, 32'h00010030);
    rchk("duty", DU, 32'h0355FF);
    ld(2, 16'hE080, 16'hD800, 16'h0, 16'h0);
    start(32'h4);
    rchk("status", ST, 32'h40);
    ld(2, 16'hE100, 16'hD800, 16'h0, 16'h0);
    bus(1'b1, ST, 32'h70);
    bus(1'b1, CT, 32'h4);
    repeat (200) @(posedge clk);
    bus(1'b1, CT, 32'h40);
    rchk("status", ST, 32'h0);
    ld(0, 16'hE000, 16'hD800, 16'h0, 16'h0);
    bus(1'b1, ST, 32'h70);
    bus(1'b1, CT, 32'h1);
    repeat (100) @(posedge clk);
    rchk("status", ST, 32'h1);
    repeat (60) @(posedge clk);
    rchk("status", ST, 32'h10);
    ld(2, 16'h4000, 16'h0101, 16'hA001, 16'hD800);
    bus(1'b1, ST, 32'h70);
    bus(1'b1, CT, 32'h4);
    repeat (1000) @(posedge clk);
    rchk("status", ST, 32'h4);
    bus(1'b1, CT, 32'h40);
    rchk("status", ST, 32'h0);
    ld(0, 16'h4000, 16'h4100, 16'hD800, 16'h0);
    bus(1'b1, ST, 32'h70);
    bus(1'b1, CT, 32'h1);
    repeat (3900) @(posedge clk);
    rchk("status", ST, 32'h1);
    repeat (400) @(posedge clk);
    rchk("status", ST, 32'h10);
    end_sim();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule // pss_sequencer_tb

bind pss_sequencer pss_sequencer_assertions #(.NCH(NCH)) pss_sequencer_assertions_i (.clk(clk),
  .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_out(pwm_out));
